/* File: rtl/tcm_pkg.sv */
`default_nettype none
package tcm_pkg;

  // ******************************************************************
  // register map (byte addresses on the apb bus)
  // ******************************************************************
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] COUNT_LOW_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_HIGH_OFFSET = 8'h08;
  localparam logic [7:0] COMPARE_A_OFFSET = 8'h0C;
  localparam logic [7:0] COMPARE_B_OFFSET = 8'h10;
  localparam logic [7:0] INT_STATUS_OFFSET = 8'h14;
  localparam logic [7:0] INT_CLEAR_OFFSET = 8'h18;
  localparam logic [7:0] INT_ENABLE_OFFSET = 8'h1C;

  // ******************************************************************
  // control register fields
  // ******************************************************************
  localparam int WIDTH_SELECT_BIT = 7;
  localparam int CAPTURE_MODE_ENABLE_BIT = 6;
  localparam int CLEAR_ON_MATCH_SELECT_BIT = 0;

  // ******************************************************************
  // event flags, one bit each in status, clear and enable
  // ******************************************************************
  localparam int FLAG_COUNT = 4;
  localparam int OVERFLOW_FLAG_BIT = 0;
  localparam int COMPARE_A_FLAG_BIT = 1;
  localparam int COMPARE_B_FLAG_BIT = 2;
  localparam int CAPTURE_FLAG_BIT = 3;

  // ******************************************************************
  // values after reset and counting limits
  // ******************************************************************
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;
  localparam logic [7:0] BYTE_BOTTOM = 8'h00;

  // ******************************************************************
  // operating modes: capture enable, width, clear-on-match
  // ******************************************************************
  typedef enum logic [2:0] {
    TCM_MODE_NORMAL8 = 3'b000,
    TCM_MODE_CLEAR8 = 3'b001,
    TCM_MODE_NORMAL16 = 3'b010,
    TCM_MODE_CAPTURE8 = 3'b011,
    TCM_MODE_CAPTURE16 = 3'b100
  } tcm_mode_t;

endpackage : tcm_pkg
`default_nettype wire

/* File: rtl/tcm_mode_decode.sv */
`default_nettype none
// decodes the three control bits into one operating mode
module tcm_mode_decode (
  input wire logic width_select_in,
  input wire logic capture_mode_enable_in,
  input wire logic clear_on_match_select_in,
  output tcm_pkg::tcm_mode_t mode_out,
  output logic wide_out,
  output logic clear_mode_out
);

  // ******************************************************************
  // mode table
  // ******************************************************************
  // clear-on-match is ignored whenever the width or capture bit is set
  always_comb begin
    if (capture_mode_enable_in) begin
      mode_out = width_select_in ? tcm_pkg::TCM_MODE_CAPTURE16 : tcm_pkg::TCM_MODE_CAPTURE8;
    end else if (width_select_in) begin
      mode_out = tcm_pkg::TCM_MODE_NORMAL16;
    end else if (clear_on_match_select_in) begin
      mode_out = tcm_pkg::TCM_MODE_CLEAR8;
    end else begin
      mode_out = tcm_pkg::TCM_MODE_NORMAL8;
    end
  end

  assign wide_out = width_select_in; // top is 0xffff in both wide modes
  assign clear_mode_out = clear_on_match_select_in & ~width_select_in & ~capture_mode_enable_in;

endmodule : tcm_mode_decode
`default_nettype wire

/* File: rtl/tcm_irq.sv */
`default_nettype none
// sticky event flags with enable mask and one level interrupt
module tcm_irq (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [tcm_pkg::FLAG_COUNT-1:0] set_in,
  input wire logic [tcm_pkg::FLAG_COUNT-1:0] ack_in,
  input wire logic clear_we_in,
  input wire logic enable_we_in,
  input wire logic [tcm_pkg::FLAG_COUNT-1:0] wdata_in,
  output logic [tcm_pkg::FLAG_COUNT-1:0] status_out,
  output logic [tcm_pkg::FLAG_COUNT-1:0] enable_out,
  output logic irq_out
);

  logic [tcm_pkg::FLAG_COUNT-1:0] status_d;

  // ******************************************************************
  // flags: a new event beats a clear in the same cycle
  // ******************************************************************
  genvar i;
  generate
    for (i = 0; i < tcm_pkg::FLAG_COUNT; i++) begin : g_flag
      always_comb begin
        status_d[i] = status_out[i];
        if (ack_in[i] || (clear_we_in && wdata_in[i])) begin
          status_d[i] = 1'b0; // serviced or written one to clear
        end
        if (set_in[i]) begin
          status_d[i] = 1'b1;
        end
      end
    end
  endgenerate

  // status register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_out <= tcm_pkg::FLAGS_RESET;
    end else begin
      status_out <= status_d;
    end
  end

  // enable register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enable_out <= tcm_pkg::FLAGS_RESET;
    end else if (enable_we_in) begin
      enable_out <= wdata_in;
    end
  end

  // interrupt level follows the flag state it will hold next cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_d & (enable_we_in ? wdata_in : enable_out));
    end
  end

endmodule : tcm_irq
`default_nettype wire

/* File: rtl/tcm_core.sv */
// Design decisions made here: the APB interface to the registers and the register offsets.
`default_nettype none
// Contract
// - normal 8-bit counts to 0xff, wraps, sets overflow
// - overflow flag only set by counting, cleared on service
// - counter value writable at any time
// - clear-on-match mode clears counter at compare a
// - compare a flag set when top reached
// - compare a writes immediate; low top wraps first
// - clear-on-match overflow set on max to zero
// - normal 16-bit counts to 0xffff, wraps, sets overflow
// - 8-bit and 16-bit capture modes selectable
// - system clock only; tick input is count enable
// - one shared high-byte latch for wide registers
// - low byte write loads latch and data together
// - low byte read copies high byte into latch
// - compare read bypasses latch except wide capture
// - mode from width, capture enable, clear-on-match bits
// - counter write blocks match on next tick
// - wide capture: a holds low, b high byte
module tcm_core (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic TIMER_TICK_IN,
  input wire logic CAPTURE_EVENT_IN,
  input wire logic [3:0] ACK_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT
);

  // ******************************************************************
  // declarations
  // ******************************************************************
  logic [7:0] control_q;
  logic [15:0] count_q;
  logic [7:0] compare_a_q;
  logic [7:0] compare_b_q;

  // shared byte for wide transfers and its read-side snapshot
  logic [7:0] high_latch_q;
  logic [7:0] read_high_q;
  logic read_loads_latch_q;
  logic block_match_q;

  // decoded mode
  tcm_pkg::tcm_mode_t mode;
  logic wide;
  logic clear_mode;
  logic capture_mode;

  // bus phase and write strobes, one per writable register word
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic wr_control;
  logic wr_count_low;
  logic wr_count_high;
  logic wr_compare_a;
  logic wr_compare_b;
  logic wr_clear;
  logic wr_enable;
  logic mapped;

  // counting and flag events
  logic match_a;
  logic match_b;
  logic tick_live;
  logic overflow_event;
  logic compare_a_event;
  logic compare_b_event;
  logic capture_event;
  logic [3:0] flag_set;

  // interrupt block view and read path
  logic [3:0] status;
  logic [3:0] enable;
  logic [31:0] read_mux;
  logic [7:0] read_high_mux;
  logic read_loads_latch;

  // ******************************************************************
  // mode decode and interrupt flags
  // ******************************************************************
  tcm_mode_decode u_mode (
    .width_select_in(control_q[tcm_pkg::WIDTH_SELECT_BIT]),
    .capture_mode_enable_in(control_q[tcm_pkg::CAPTURE_MODE_ENABLE_BIT]),
    .clear_on_match_select_in(control_q[tcm_pkg::CLEAR_ON_MATCH_SELECT_BIT]),
    .mode_out(mode),
    .wide_out(wide),
    .clear_mode_out(clear_mode)
  );

  // capture modes reuse the compare registers as the capture register
  assign capture_mode = (mode == tcm_pkg::TCM_MODE_CAPTURE8) ||
                        (mode == tcm_pkg::TCM_MODE_CAPTURE16);

  tcm_irq u_irq (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .set_in(flag_set),
    .ack_in(ACK_IN),
    .clear_we_in(wr_clear),
    .enable_we_in(wr_enable),
    .wdata_in(PWDATA_IN[3:0]),
    .status_out(status),
    .enable_out(enable),
    .irq_out(IRQ_OUT)
  );

  // ******************************************************************
  // apb decode
  // ******************************************************************
  // the slave answers in the first access cycle: pready is set by setup
  assign setup = PSEL_IN & ~PENABLE_IN;
  assign access = PSEL_IN & PENABLE_IN & PREADY_OUT;
  assign wr = access & PWRITE_IN;
  assign rd = access & ~PWRITE_IN;
  assign wr_control = wr && (PADDR_IN == tcm_pkg::CONTROL_OFFSET);
  assign wr_count_low = wr && (PADDR_IN == tcm_pkg::COUNT_LOW_OFFSET);
  assign wr_count_high = wr && (PADDR_IN == tcm_pkg::COUNT_HIGH_OFFSET);
  assign wr_compare_a = wr && (PADDR_IN == tcm_pkg::COMPARE_A_OFFSET);
  assign wr_compare_b = wr && (PADDR_IN == tcm_pkg::COMPARE_B_OFFSET);
  assign wr_clear = wr && (PADDR_IN == tcm_pkg::INT_CLEAR_OFFSET);
  assign wr_enable = wr && (PADDR_IN == tcm_pkg::INT_ENABLE_OFFSET);

  // decode of every implemented word; anything else is an error
  always_comb begin
    unique case (PADDR_IN)
      tcm_pkg::CONTROL_OFFSET,
      tcm_pkg::COUNT_LOW_OFFSET,
      tcm_pkg::COUNT_HIGH_OFFSET,
      tcm_pkg::COMPARE_A_OFFSET,
      tcm_pkg::COMPARE_B_OFFSET,
      tcm_pkg::INT_STATUS_OFFSET,
      tcm_pkg::INT_CLEAR_OFFSET,
      tcm_pkg::INT_ENABLE_OFFSET: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ******************************************************************
  // read data and latch side effects
  // ******************************************************************
  // data and the high byte are sampled together in the setup cycle so a
  // tick between setup and access cannot tear the 16-bit value
  always_comb begin
    read_mux = tcm_pkg::READ_ZERO;
    read_high_mux = high_latch_q;
    read_loads_latch = 1'b0;
    unique case (PADDR_IN)
      tcm_pkg::CONTROL_OFFSET: begin
        read_mux[7:0] = control_q;
      end
      tcm_pkg::COUNT_LOW_OFFSET: begin
        read_mux[7:0] = count_q[7:0];
        read_high_mux = count_q[15:8];
        read_loads_latch = 1'b1;
      end
      tcm_pkg::COUNT_HIGH_OFFSET: begin
        read_mux[7:0] = wide ? high_latch_q : count_q[15:8];
      end
      tcm_pkg::COMPARE_A_OFFSET: begin
        read_mux[7:0] = compare_a_q;
        read_high_mux = compare_b_q;
        read_loads_latch = (mode == tcm_pkg::TCM_MODE_CAPTURE16);
      end
      tcm_pkg::COMPARE_B_OFFSET: begin
        // output compare use reads the stored byte directly
        read_mux[7:0] = (mode == tcm_pkg::TCM_MODE_CAPTURE16) ?
                        high_latch_q : compare_b_q;
      end
      tcm_pkg::INT_STATUS_OFFSET: begin
        read_mux[3:0] = status;
      end
      tcm_pkg::INT_ENABLE_OFFSET: begin
        read_mux[3:0] = enable;
      end
      default: begin
        read_mux = tcm_pkg::READ_ZERO; // write-only clear and unmapped words
      end
    endcase
  end

  // apb answer flops: ready for one cycle after each setup
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= tcm_pkg::READ_ZERO;
    end else begin
      // zero wait states: a slower read path would need ready held back
      PREADY_OUT <= setup;
      if (setup) begin
        PSLVERR_OUT <= ~mapped;
        PRDATA_OUT <= PWRITE_IN ? tcm_pkg::READ_ZERO : read_mux;
      end
    end
  end

  // pending latch load for a read that is still in its setup cycle
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      read_high_q <= tcm_pkg::BYTE_RESET;
      read_loads_latch_q <= 1'b0;
    end else if (setup) begin
      read_high_q <= read_high_mux;
      read_loads_latch_q <= read_loads_latch & ~PWRITE_IN;
    end
  end

  // ******************************************************************
  // shared high byte latch
  // ******************************************************************
  // any wide register's high byte passes through this one latch, so an
  // interrupt routine touching another register can corrupt a pair
  // a read and a write never share a cycle, so the order below is free
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      high_latch_q <= tcm_pkg::BYTE_RESET;
    end else if (rd && read_loads_latch_q) begin
      high_latch_q <= read_high_q;
    end else if (wr_count_high || (wide && wr_compare_b)) begin
      high_latch_q <= PWDATA_IN[7:0];
    end
  end

  // control register
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      control_q <= tcm_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      // unused control bits stay zero so they read back as zero
      control_q <= '0;
      control_q[tcm_pkg::WIDTH_SELECT_BIT] <= PWDATA_IN[tcm_pkg::WIDTH_SELECT_BIT];
      control_q[tcm_pkg::CAPTURE_MODE_ENABLE_BIT] <=
        PWDATA_IN[tcm_pkg::CAPTURE_MODE_ENABLE_BIT];
      control_q[tcm_pkg::CLEAR_ON_MATCH_SELECT_BIT] <=
        PWDATA_IN[tcm_pkg::CLEAR_ON_MATCH_SELECT_BIT];
    end
  end

  // ******************************************************************
  // compare matching
  // ******************************************************************
  // a software counter write overrides the tick in the same cycle
  assign tick_live = TIMER_TICK_IN & ~wr_count_low;
  // match a spans both bytes in wide modes, only the low byte otherwise
  assign match_a = wide ? (count_q == {compare_b_q, compare_a_q})
                        : (count_q[7:0] == compare_a_q);
  // compare b has no wide form: it is then the high byte of a
  assign match_b = ~wide & (count_q[7:0] == compare_b_q);

  // compare a is the capture register in capture modes; no wide b unit
  assign compare_a_event = tick_live & match_a & ~block_match_q & ~capture_mode;
  assign compare_b_event = tick_live & match_b & ~block_match_q &
                           (mode != tcm_pkg::TCM_MODE_CAPTURE16);
  // overflow marks the tick that carries the count from max to zero
  assign overflow_event = tick_live &
                          (wide ? (count_q == tcm_pkg::WORD_MAX)
                                : (count_q[7:0] == tcm_pkg::BYTE_MAX));
  // captures are ignored outside the capture modes
  assign capture_event = CAPTURE_EVENT_IN & capture_mode;

  // one set line per sticky status bit
  always_comb begin
    flag_set = '0;
    flag_set[tcm_pkg::OVERFLOW_FLAG_BIT] = overflow_event;
    flag_set[tcm_pkg::COMPARE_A_FLAG_BIT] = compare_a_event;
    flag_set[tcm_pkg::COMPARE_B_FLAG_BIT] = compare_b_event;
    flag_set[tcm_pkg::CAPTURE_FLAG_BIT] = capture_event;
  end

  // match blocking holds until the next tick, even with the timer stopped
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      block_match_q <= 1'b0;
    end else if (wr_count_low) begin
      block_match_q <= 1'b1;
    end else if (TIMER_TICK_IN) begin
      block_match_q <= 1'b0;
    end
  end

  // ******************************************************************
  // counter
  // ******************************************************************
  // all updates run on the system clock; the tick only qualifies them
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      count_q <= tcm_pkg::COUNT_RESET;
    end else if (wr_count_low) begin
      // wide writes take the latched high byte in the same cycle
      count_q <= wide ? {high_latch_q, PWDATA_IN[7:0]}
                      : {count_q[15:8], PWDATA_IN[7:0]};
    end else if (TIMER_TICK_IN) begin
      // wide mode never clears on match: its top is the full word
      if (wide) begin
        count_q <= count_q + 16'h0001;
      end else if (clear_mode && match_a && !block_match_q) begin
        count_q[7:0] <= tcm_pkg::BYTE_BOTTOM;
      end else begin
        count_q[7:0] <= count_q[7:0] + 8'h01;
      end
    end
  end

  // ******************************************************************
  // compare and capture registers
  // ******************************************************************
  // no double buffering: a new top below the count is missed until wrap
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      compare_a_q <= tcm_pkg::BYTE_RESET;
    end else if (wr_compare_a) begin
      compare_a_q <= PWDATA_IN[7:0];
    end else if (capture_event) begin
      compare_a_q <= count_q[7:0];
    end
  end

  // in wide modes compare b is loaded only with a low byte write or a capture
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      compare_b_q <= tcm_pkg::BYTE_RESET;
    end else if (wide && wr_compare_a) begin
      compare_b_q <= high_latch_q;
    end else if (!wide && wr_compare_b) begin
      // narrow modes keep compare b as a unit of its own
      compare_b_q <= PWDATA_IN[7:0];
    end else if (capture_event && wide && !wr_compare_a) begin
      compare_b_q <= count_q[15:8];
    end
  end

endmodule : tcm_core
`default_nettype wire

/* File: testbench/tcm_stim_src.sv */
`default_nettype none
// ******************************************************************
// far-side stimulus: count enable and capture trigger
// ******************************************************************
module tcm_stim_src (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input wire logic cap_req_in,
  output logic tick_out,
  output logic cap_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // the tick is a one-clock enable, never a clock of its own
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= run_in;
    end
  end
  // capture trigger follows the request one clock late
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cap_out <= 1'b0;
    end else begin
      cap_out <= cap_req_in;
    end
  end
endmodule : tcm_stim_src
`default_nettype wire

/* File: testbench/tcm_core_asserts.sv */
`default_nettype none
// ******************************************************************
// bus and interrupt checks at the top ports
// ******************************************************************
module tcm_core_asserts (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic TIMER_TICK_IN,
  input wire logic CAPTURE_EVENT_IN,
  input wire logic [3:0] ACK_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrl_q;
  logic [3:0] en_q;
  logic done;
  logic mapped;
  logic rd_done;
  assign done = PSEL_IN && PENABLE_IN && PREADY_OUT;
  assign rd_done = done && !PWRITE_IN;
  assign mapped = PADDR_IN <= 8'h1C && PADDR_IN[1:0] == 2'b00;
  // shadows of control and enable as software wrote them
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctrl_q <= 8'h00;
    end else if (done && PWRITE_IN && PADDR_IN == tcm_pkg::CONTROL_OFFSET) begin
      ctrl_q <= PWDATA_IN[7:0];
    end
  end
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      en_q <= 4'h0;
    end else if (done && PWRITE_IN && PADDR_IN == tcm_pkg::INT_ENABLE_OFFSET) begin
      en_q <= PWDATA_IN[3:0];
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  chk_ready_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("no ready in access cycle");
  chk_ready_only_access: assert property (PREADY_OUT |-> $past(PSEL_IN && !PENABLE_IN))
    else $error("ready without setup");
  chk_err_unmapped: assert property (done && !mapped |-> PSLVERR_OUT)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (done && mapped |-> !PSLVERR_OUT)
    else $error("mapped access refused");
  chk_rdata_upper: assert property (rd_done |-> PRDATA_OUT[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  chk_clear_reads_zero: assert property (rd_done && PADDR_IN == tcm_pkg::INT_CLEAR_OFFSET
    |-> PRDATA_OUT == 32'h0000_0000)
    else $error("clear register read nonzero");
  chk_mode_readback: assert property (rd_done && PADDR_IN == tcm_pkg::CONTROL_OFFSET
    |-> PRDATA_OUT[7:0] == (ctrl_q & 8'hC1))
    else $error("mode bits read back wrong");
  chk_irq_masked: assert property (IRQ_OUT |-> en_q != 4'h0 || $past(en_q) != 4'h0)
    else $error("interrupt with all enables off");
  chk_irq_reset: assert property ($rose(RESETN_IN) |-> !IRQ_OUT)
    else $error("interrupt high after reset");
endmodule : tcm_core_asserts
bind tcm_core tcm_core_asserts chk_u (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .TIMER_TICK_IN(TIMER_TICK_IN), .CAPTURE_EVENT_IN(CAPTURE_EVENT_IN),
  .ACK_IN(ACK_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

/* File: testbench/test_timer_counter_modes_wide_access.sv */
`default_nettype none
module test_timer_counter_modes_wide_access;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = tcm_pkg::CONTROL_OFFSET;
  localparam logic [7:0] CNTL = tcm_pkg::COUNT_LOW_OFFSET;
  localparam logic [7:0] CNTH = tcm_pkg::COUNT_HIGH_OFFSET;
  localparam logic [7:0] CMPA = tcm_pkg::COMPARE_A_OFFSET;
  localparam logic [7:0] CMPB = tcm_pkg::COMPARE_B_OFFSET;
  localparam logic [7:0] STAT = tcm_pkg::INT_STATUS_OFFSET;
  localparam logic [7:0] CLR = tcm_pkg::INT_CLEAR_OFFSET;
  localparam logic [7:0] ENA = tcm_pkg::INT_ENABLE_OFFSET;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic run = 1'b0;
  logic cap_req = 1'b0;
  logic [3:0] ack = 4'h0;
  logic tick;
  logic cap;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int miscompares = 0;
  int compares = 0;
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  tcm_core dut_u (.CLK_IN(clk), .RESETN_IN(resetn), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .TIMER_TICK_IN(tick),
    .CAPTURE_EVENT_IN(cap), .ACK_IN(ack), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .IRQ_OUT(irq));
  tcm_stim_src src_u (.clk_in(clk), .resetn_in(resetn), .run_in(run), .cap_req_in(cap_req),
    .tick_out(tick), .cap_out(cap));
  // ******************************************************************
  // bus tasks and checks
  // ******************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one transfer; a dead slave is caught by the watchdog, not here
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    apb(1'b0, a, 8'h00, r);
    chk(r, exp);
  endtask : rd
  // n count enables, then idle so flags reach status
  task automatic ticks(input int n);
    @(posedge clk);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : ticks
  task automatic capture;
    @(posedge clk);
    cap_req <= 1'b1;
    @(posedge clk);
    cap_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : capture
  task automatic final_report;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // ******************************************************************
  // scenarios
  // ******************************************************************
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd(CTL, 8'h00);
    rd(STAT, 8'h00);
    rd(8'h20, 8'h00);
    // normal 8-bit wrap, status is read-only, mask and service
    wr(ENA, 8'h0F);
    wr(CNTL, 8'hFE);
    ticks(2);
    rd(CNTL, 8'h00);
    rd(STAT, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(STAT, 8'h00);
    wr(ENA, 8'h00);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rd(STAT, 8'h01);
    wr(ENA, 8'h0F);
    @(posedge clk);
    ack <= 4'h1;
    @(posedge clk);
    ack <= 4'h0;
    repeat (2) @(posedge clk);
    rd(STAT, 8'h00);
    // clear-on-match: top from compare a, low top forces a wrap first
    wr(CTL, 8'h01);
    wr(CMPA, 8'h05);
    wr(CNTL, 8'h00);
    ticks(6);
    rd(CNTL, 8'h00);
    rd(STAT, 8'h02);
    wr(CLR, 8'h0F);
    wr(CNTL, 8'h04);
    wr(CMPA, 8'h02);
    ticks(252);
    rd(STAT, 8'h01);
    ticks(3);
    rd(CNTL, 8'h00);
    rd(STAT, 8'h07);
    // counter write equal to top must not match on the next tick
    wr(CLR, 8'h0F);
    wr(CMPA, 8'h03);
    wr(CNTL, 8'h03);
    ticks(1);
    rd(CNTL, 8'h04);
    rd(STAT, 8'h00);
    // normal 16-bit through the shared high-byte latch
    wr(CTL, 8'h80);
    wr(CNTH, 8'hFF);
    wr(CNTL, 8'hFE);
    rd(CNTL, 8'hFE);
    rd(CNTH, 8'hFF);
    ticks(2);
    rd(CNTL, 8'h00);
    rd(CNTH, 8'h00);
    rd(STAT, 8'h01);
    wr(CNTH, 8'h12);
    wr(CMPA, 8'h34);
    rd(CNTL, 8'h00);
    rd(CMPA, 8'h34);
    rd(CMPB, 8'h12);
    // wide and narrow capture
    wr(CTL, 8'hC0);
    wr(CNTH, 8'hAB);
    wr(CNTL, 8'hCD);
    capture();
    rd(CMPA, 8'hCD);
    rd(CMPB, 8'hAB);
    rd(STAT, 8'h09);
    wr(CTL, 8'h40);
    wr(CNTL, 8'h77);
    capture();
    rd(CMPA, 8'h77);
    final_report();
  end
endmodule : test_timer_counter_modes_wide_access
`default_nettype wire
